// [rtl/osc_select_pkg.sv]
package osc_select_pkg;
    // Register byte offsets on the AXI4-Lite bus
    localparam logic [3:0] REQ_CTRL_OFFSET = 4'h0;
    localparam logic [3:0] CUR_STATUS_OFFSET = 4'h4;
    localparam logic [3:0] MON_STATUS_OFFSET = 4'h8;
    // Field layout shared by the request and current status registers
    localparam int SRC_LSB = 4;
    localparam int SRC_W = 3;
    localparam int DIV_LSB = 0;
    localparam int DIV_W = 4;
    // Monitor status bit positions
    localparam int MON_FAILSAFE_BIT = 0;
    localparam int MON_BUSY_BIT = 1;
    localparam int MON_CRYSTAL_OK_BIT = 2;
    // Source codes; unlisted codes are reserved
    localparam logic [2:0] SRC_HFINT_32M = 3'h0;
    localparam logic [2:0] SRC_EXTERNAL = 3'h2;
    localparam logic [2:0] SRC_LFINT = 3'h5;
    localparam logic [2:0] SRC_HFINT_4M = 3'h6;
    // Divider reset values
    localparam logic [3:0] DIV_HFINT_4M_RESET = 4'h2;
    localparam logic [3:0] DIV_OTHER_RESET = 4'h0;
    // External mode codes
    localparam logic [2:0] EXT_HIGH_POWER_CLOCK = 3'h0;
    localparam logic [2:0] EXT_MEDIUM_POWER_CLOCK = 3'h1;
    localparam logic [2:0] EXT_LOW_POWER_CLOCK = 3'h2;
    localparam logic [2:0] EXT_LOW_POWER_CRYSTAL = 3'h4;
    localparam logic [2:0] EXT_MEDIUM_GAIN_CRYSTAL = 3'h5;
    localparam logic [2:0] EXT_HIGH_GAIN_CRYSTAL = 3'h6;
    // Timing
    localparam int CLK_PERIOD_NS = 20;
    localparam int FAILSAFE_MONITOR_TIMEOUT_NS = 81920;
    localparam int FAILSAFE_MONITOR_TIMEOUT_CYCLES = FAILSAFE_MONITOR_TIMEOUT_NS / CLK_PERIOD_NS;
    localparam logic [12:0] FAILSAFE_MONITOR_LIMIT = 13'(FAILSAFE_MONITOR_TIMEOUT_CYCLES);
    localparam logic [10:0] CRYSTAL_STARTUP_EDGES = 11'h400;
    localparam logic [1:0] BOOT_CYCLES = 2'h3;
    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Switch sequencer states, Gray along the path
    typedef enum logic [1:0] {
        SW_IDLE = 2'b00,
        SW_WAIT = 2'b01,
        SW_COMMIT = 2'b11
    } switch_state_t;
endpackage

// [rtl/osc_source_select.sv]
`timescale 1ns/10ps
module osc_source_select (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [2:0] reset_osc_select,
    input wire logic [2:0] ext_osc_mode,
    input wire logic clock_switch_enable,
    input wire logic ext_clk_pin,
    input wire logic hfint_ready,
    input wire logic lfint_ready,
    output logic [2:0] clock_source_sel,
    output logic [3:0] clock_divider_sel,
    output logic [2:0] ext_mode_sel,
    output logic crystal_amp_enable,
    output logic failsafe_active
);

    ////////////////////////////////////////////////////////////////////////
    // Helpers
    function automatic logic is_reserved(input logic [2:0] code);
        is_reserved = !(code == osc_select_pkg::SRC_HFINT_32M || code == osc_select_pkg::SRC_EXTERNAL ||
                        code == osc_select_pkg::SRC_LFINT || code == osc_select_pkg::SRC_HFINT_4M);
    endfunction

    function automatic logic [3:0] reset_divider(input logic [2:0] code);
        reset_divider = (code == osc_select_pkg::SRC_HFINT_4M) ? osc_select_pkg::DIV_HFINT_4M_RESET
                                                               : osc_select_pkg::DIV_OTHER_RESET;
    endfunction

    function automatic logic is_crystal(input logic [2:0] mode);
        is_crystal = (mode == osc_select_pkg::EXT_LOW_POWER_CRYSTAL) ||
                     (mode == osc_select_pkg::EXT_MEDIUM_GAIN_CRYSTAL) ||
                     (mode == osc_select_pkg::EXT_HIGH_GAIN_CRYSTAL);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers: straps and pins all come from outside
    localparam int SYNC_W = 12;
    logic [SYNC_W-1:0] sync_in; // Raw pin vector
    logic [SYNC_W-1:0] sync1_q; // First stage, read only by second stage
    logic [SYNC_W-1:0] sync2_q; // Usable synchronised copy
    assign sync_in = {reset_osc_select, ext_osc_mode, clock_switch_enable, ext_clk_pin, hfint_ready, lfint_ready, 2'b00};

    genvar gi;
    generate
        for (gi = 0; gi < SYNC_W; gi++)
        begin : g_sync
            always_ff @(posedge aclk)
            begin
                sync1_q[gi] <= sync_in[gi];
                sync2_q[gi] <= sync1_q[gi];
            end
        end
    endgenerate

    logic [2:0] rst_sel_s;
    logic [2:0] ext_mode_s;
    logic clock_switch_enable_s;
    logic ext_clk_s;
    logic hf_rdy_s;
    logic lf_rdy_s;
    assign rst_sel_s = sync2_q[11:9];
    assign ext_mode_s = sync2_q[8:6];
    assign clock_switch_enable_s = sync2_q[5];
    assign ext_clk_s = sync2_q[4];
    assign hf_rdy_s = sync2_q[3];
    assign lf_rdy_s = sync2_q[2];

    // Edge detect on the synchronised external clock
    logic ext_clk_prev_q;
    logic ext_edge;
    always_ff @(posedge aclk)
    begin
        ext_clk_prev_q <= ext_clk_s;
    end
    assign ext_edge = ext_clk_s && !ext_clk_prev_q;

    ////////////////////////////////////////////////////////////////////////
    // Boot: wait for strap synchronisers to fill, then load once
    logic [1:0] boot_cnt_q;
    logic boot_done_q;
    logic boot_load;
    assign boot_load = !boot_done_q && (boot_cnt_q == osc_select_pkg::BOOT_CYCLES);
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            boot_cnt_q <= 2'h0;
            boot_done_q <= 1'b0;
        end
        else if (!boot_done_q)
        begin
            boot_cnt_q <= boot_cnt_q + 2'h1;
            boot_done_q <= boot_load;
        end
    end

    // Strap values latched at boot; config words do not change at run time
    logic [2:0] ext_mode_q;
    logic clock_switch_enable_q;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ext_mode_q <= osc_select_pkg::EXT_HIGH_POWER_CLOCK;
            clock_switch_enable_q <= 1'b0;
        end
        else if (boot_load)
        begin
            ext_mode_q <= ext_mode_s;
            clock_switch_enable_q <= clock_switch_enable_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write channel: address and data taken in either order
    logic aw_held_q;
    logic w_held_q;
    logic [3:0] awaddr_q;
    logic [31:0] wdata_q;
    logic wstrb0_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic wr_fire;
    assign s_axi_awready = boot_done_q && !aw_held_q && !bvalid_q;
    assign s_axi_wready = boot_done_q && !w_held_q && !bvalid_q;
    assign wr_fire = aw_held_q && w_held_q && !bvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            awaddr_q <= 4'h0;
            wdata_q <= 32'h0;
            wstrb0_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= osc_select_pkg::RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb0_q <= s_axi_wstrb[0];
            end
            if (wr_fire)
            begin
                aw_held_q <= 1'b0;
                w_held_q <= 1'b0;
                bvalid_q <= 1'b1;
                // Only the request register is writable; status writes are harmless and answered OKAY, unmapped addresses get SLVERR
                bresp_q <= (awaddr_q == osc_select_pkg::REQ_CTRL_OFFSET ||
                            awaddr_q == osc_select_pkg::CUR_STATUS_OFFSET ||
                            awaddr_q == osc_select_pkg::MON_STATUS_OFFSET) ? osc_select_pkg::RESP_OKAY
                                                                            : osc_select_pkg::RESP_SLVERR;
            end
            else if (bvalid_q && s_axi_bready)
            begin
                bvalid_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Request register
    logic [2:0] req_src_q;
    logic [3:0] req_div_q;
    logic ctrl_write;
    logic ctrl_accept;
    logic [2:0] wr_src;
    assign wr_src = wdata_q[osc_select_pkg::SRC_LSB +: osc_select_pkg::SRC_W];
    assign ctrl_write = wr_fire && wstrb0_q && (awaddr_q == osc_select_pkg::REQ_CTRL_OFFSET);
    assign ctrl_accept = ctrl_write && clock_switch_enable_q && !is_reserved(wr_src);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            req_src_q <= osc_select_pkg::SRC_HFINT_32M;
            req_div_q <= osc_select_pkg::DIV_OTHER_RESET;
        end
        else if (boot_load)
        begin
            // Reserved strap codes fall back to the 32 MHz internal source
            req_src_q <= is_reserved(rst_sel_s) ? osc_select_pkg::SRC_HFINT_32M : rst_sel_s;
            req_div_q <= reset_divider(rst_sel_s);
        end
        else if (ctrl_accept)
        begin
            req_src_q <= wr_src;
            req_div_q <= wdata_q[osc_select_pkg::DIV_LSB +: osc_select_pkg::DIV_W];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Switch sequencer and current source
    osc_select_pkg::switch_state_t sw_state_q;
    logic [2:0] cur_src_q;
    logic [3:0] cur_div_q;
    logic [10:0] ost_cnt_q;
    logic [12:0] failsafe_monitor_cnt_q;
    logic failsafe_q;
    logic failsafe_monitor_trip;
    logic target_ready;
    logic ext_ok;
    logic cur_external;

    // Crystals wait out the startup count, logic-level clocks need one edge
    assign ext_ok = is_crystal(ext_mode_q) ? (ost_cnt_q == osc_select_pkg::CRYSTAL_STARTUP_EDGES)
                                           : (ost_cnt_q != 11'h0);
    always_comb
    begin
        case (req_src_q)
            osc_select_pkg::SRC_EXTERNAL: target_ready = ext_ok;
            osc_select_pkg::SRC_LFINT: target_ready = lf_rdy_s;
            default: target_ready = hf_rdy_s;
        endcase
    end

    assign cur_external = (cur_src_q == osc_select_pkg::SRC_EXTERNAL);
    assign failsafe_monitor_trip = cur_external && !failsafe_q && (failsafe_monitor_cnt_q == osc_select_pkg::FAILSAFE_MONITOR_LIMIT);

    // Startup edge counter runs while waiting; a newer request restarts it so no stale count is reused
    always_ff @(posedge aclk)
    begin
        if (!aresetn || sw_state_q == osc_select_pkg::SW_IDLE || ctrl_accept)
        begin
            ost_cnt_q <= 11'h0;
        end
        else if (ext_edge && ost_cnt_q != osc_select_pkg::CRYSTAL_STARTUP_EDGES)
        begin
            ost_cnt_q <= ost_cnt_q + 11'h1;
        end
    end

    // Clock monitor: counts system cycles since the last external edge
    always_ff @(posedge aclk)
    begin
        if (!aresetn || ext_edge || !cur_external)
        begin
            failsafe_monitor_cnt_q <= 13'h0;
        end
        else if (failsafe_monitor_cnt_q != osc_select_pkg::FAILSAFE_MONITOR_LIMIT)
        begin
            failsafe_monitor_cnt_q <= failsafe_monitor_cnt_q + 13'h1;
        end
    end

    // Sequencer: a new request waits in WAIT until its source runs
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sw_state_q <= osc_select_pkg::SW_IDLE;
        end
        else
        begin
            case (sw_state_q)
                osc_select_pkg::SW_IDLE:
                begin
                    if (ctrl_accept)
                    begin
                        sw_state_q <= osc_select_pkg::SW_WAIT;
                    end
                end
                osc_select_pkg::SW_WAIT:
                begin
                    // A newer request restarts the wait on the new target
                    if (ctrl_accept)
                    begin
                        sw_state_q <= osc_select_pkg::SW_WAIT;
                    end
                    else if (target_ready)
                    begin
                        sw_state_q <= osc_select_pkg::SW_COMMIT;
                    end
                end
                osc_select_pkg::SW_COMMIT:
                begin
                    sw_state_q <= ctrl_accept ? osc_select_pkg::SW_WAIT : osc_select_pkg::SW_IDLE;
                end
                default:
                begin
                    sw_state_q <= osc_select_pkg::SW_IDLE;
                end
            endcase
        end
    end

    // Current source and divider; fail-safe overrides a pending commit
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cur_src_q <= osc_select_pkg::SRC_HFINT_32M;
            cur_div_q <= osc_select_pkg::DIV_OTHER_RESET;
            failsafe_q <= 1'b0;
        end
        else if (boot_load)
        begin
            cur_src_q <= is_reserved(rst_sel_s) ? osc_select_pkg::SRC_HFINT_32M : rst_sel_s;
            cur_div_q <= reset_divider(rst_sel_s);
        end
        else if (failsafe_monitor_trip)
        begin
            cur_src_q <= osc_select_pkg::SRC_HFINT_4M;
            failsafe_q <= 1'b1;
        end
        else if (sw_state_q == osc_select_pkg::SW_COMMIT && !ctrl_accept)
        begin
            cur_src_q <= req_src_q;
            cur_div_q <= req_div_q;
            failsafe_q <= 1'b0;
        end
    end

    assign clock_source_sel = cur_src_q;
    assign clock_divider_sel = cur_div_q;
    assign ext_mode_sel = ext_mode_q;
    assign failsafe_active = failsafe_q;
    // Amplifier runs while a crystal is in use or being started
    assign crystal_amp_enable = is_crystal(ext_mode_q) &&
                                (cur_external || (req_src_q == osc_select_pkg::SRC_EXTERNAL));

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read channel
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    assign s_axi_arready = boot_done_q && !rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0;
            rresp_q <= osc_select_pkg::RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            rvalid_q <= 1'b1;
            rresp_q <= osc_select_pkg::RESP_OKAY;
            case (s_axi_araddr)
                osc_select_pkg::REQ_CTRL_OFFSET: rdata_q <= {25'h0, req_src_q, req_div_q};
                osc_select_pkg::CUR_STATUS_OFFSET: rdata_q <= {25'h0, cur_src_q, cur_div_q};
                osc_select_pkg::MON_STATUS_OFFSET: rdata_q <= {29'h0, ext_ok,
                                                           sw_state_q != osc_select_pkg::SW_IDLE, failsafe_q};
                default:
                begin
                    rdata_q <= 32'h0;
                    rresp_q <= osc_select_pkg::RESP_SLVERR;
                end
            endcase
        end
        else if (rvalid_q && s_axi_rready)
        begin
            rvalid_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    sequence seq_reserved_write;
        ctrl_write && is_reserved(wr_src) && !boot_load;
    endsequence
    sequence seq_commit;
        sw_state_q == osc_select_pkg::SW_COMMIT && !ctrl_accept && !failsafe_monitor_trip;
    endsequence

    AST_RESERVED_IGNORED: assert property (@(posedge aclk) disable iff (!aresetn)
        seq_reserved_write |=> $stable(req_src_q) && $stable(req_div_q))
        else $error("Reserved source write changed the request register");
    AST_LOCKED_CTRL: assert property (@(posedge aclk) disable iff (!aresetn)
        boot_done_q && !clock_switch_enable_q |=> $stable({req_src_q, req_div_q}))
        else $error("Request register changed while switching disabled");
    AST_BOOT_DIVIDER: assert property (@(posedge aclk) disable iff (!aresetn)
        boot_load |=> req_div_q == ((req_src_q == osc_select_pkg::SRC_HFINT_4M) ?
                                    osc_select_pkg::DIV_HFINT_4M_RESET : osc_select_pkg::DIV_OTHER_RESET))
        else $error("Boot divider wrong for source code");
    AST_BOOT_MATCH: assert property (@(posedge aclk) disable iff (!aresetn)
        boot_load |=> cur_src_q == req_src_q && cur_div_q == req_div_q)
        else $error("Status differs from request after boot");
    AST_FAILSAFE: assert property (@(posedge aclk) disable iff (!aresetn)
        failsafe_monitor_trip |=> cur_src_q == osc_select_pkg::SRC_HFINT_4M && failsafe_q)
        else $error("Lost external clock did not fall back");
    AST_COMMIT_ONLY: assert property (@(posedge aclk) disable iff (!aresetn)
        boot_done_q && !$past(boot_load) && !failsafe_monitor_trip && !$past(failsafe_monitor_trip) && $changed(cur_div_q)
        |-> $past(sw_state_q) == osc_select_pkg::SW_COMMIT)
        else $error("Current divider changed without a commit");
    AST_COMMIT_READY: assert property (@(posedge aclk) disable iff (!aresetn)
        seq_commit |-> $past(target_ready) ##1 cur_src_q == $past(req_src_q))
        else $error("Commit without ready source");
    AST_STATUS_BIT7: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_arvalid && s_axi_arready && s_axi_araddr == osc_select_pkg::CUR_STATUS_OFFSET
        |=> rdata_q[7] == 1'b0 && rdata_q[6:0] == $past({cur_src_q, cur_div_q}))
        else $error("Status read data wrong");
    AST_CTRL_BIT7: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_arvalid && s_axi_arready && s_axi_araddr == osc_select_pkg::REQ_CTRL_OFFSET |=> rdata_q[31:7] == 25'h0)
        else $error("Request read upper bits not zero");

endmodule // osc_source_select

// [testbench/testbench.sv]
`timescale 1ns/10ps
module testbench;
////////////////////////////////////////////////////////////////////////////////
// Bench signals
logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
logic [3:0] s_axi_awaddr, s_axi_wstrb, s_axi_araddr, clock_divider_sel;
logic [31:0] s_axi_wdata, s_axi_rdata, rd;
logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
logic [1:0] s_axi_bresp, s_axi_rresp, resp;
logic [2:0] reset_osc_select, ext_osc_mode, clock_source_sel, ext_mode_sel;
logic clock_switch_enable, ext_clk_pin, hfint_ready, lfint_ready, crystal_amp_enable, failsafe_active;
logic ext_run; // Toggles the external clock pin while set
int err_count, comparisons, cycles;
localparam logic [3:0] REQ = osc_select_pkg::REQ_CTRL_OFFSET;
localparam logic [3:0] CUR = osc_select_pkg::CUR_STATUS_OFFSET;
localparam logic [1:0] OK = osc_select_pkg::RESP_OKAY;
logic [2:0] rsv [4] = '{3'h1, 3'h3, 3'h4, 3'h7}; // Reserved source codes

osc_source_select dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .reset_osc_select, .ext_osc_mode, .clock_switch_enable, .ext_clk_pin, .hfint_ready, .lfint_ready,
    .clock_source_sel, .clock_divider_sel, .ext_mode_sel, .crystal_amp_enable, .failsafe_active
);

////////////////////////////////////////////////////////////////////////////////
// Clock, external pin and hang guard
initial
begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
end

// One rising pin edge every two system clocks, slow enough for the sync chain
always @(posedge aclk)
begin
    if (ext_run)
        ext_clk_pin <= ~ext_clk_pin;
end

// Whole run needs about 6300 cycles; the ceiling leaves margin
always @(posedge aclk)
begin
    cycles <= cycles + 1;
    if (cycles == 12000)
    begin
        err_count = err_count + 1;
        stop_test();
    end
end

////////////////////////////////////////////////////////////////////////////////
// Tasks
task automatic stop_test();
    if (err_count == 0 && comparisons > 0)
        $display("TB: PASS");
    else
        $display("TB: FAIL");
    $finish;
endtask

task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons = comparisons + 1;
    if (seen !== exp)
    begin
        err_count = err_count + 1;
        $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
endtask

// Both channels offered together, each released once taken
task automatic axi_write(input logic [3:0] a, input logic [31:0] d);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok))
    begin
        @(posedge aclk);
        if (!aw_ok && s_axi_awready === 1'b1)
        begin
            aw_ok = 1'b1;
            s_axi_awvalid <= 1'b0;
        end
        if (!w_ok && s_axi_wready === 1'b1)
        begin
            w_ok = 1'b1;
            s_axi_wvalid <= 1'b0;
        end
    end
    while (s_axi_bvalid !== 1'b1)
        @(posedge aclk);
    s_axi_bready <= 1'b0;
    check("write resp", 32'(s_axi_bresp), 32'(OK));
endtask

task automatic axi_read(input logic [3:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    @(posedge aclk);
    while (s_axi_arready !== 1'b1)
        @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    @(posedge aclk);
    while (s_axi_rvalid !== 1'b1)
        @(posedge aclk);
    rd = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
endtask

task automatic expect_reg(input string what, input logic [3:0] a, input logic [31:0] exp, input logic [1:0] er);
    axi_read(a);
    check(what, rd, exp);
    check({what, " resp"}, 32'(resp), 32'(er));
endtask

// Straps settle inside reset, reset held five cycles
task automatic do_reset(input logic [2:0] src, input logic [2:0] mode, input logic en);
    @(posedge aclk);
    aresetn <= 1'b0;
    reset_osc_select <= src;
    ext_osc_mode <= mode;
    clock_switch_enable <= en;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (6) @(posedge aclk);
endtask

// Bounded wait for the current source output to reach a code
task automatic wait_src(input logic [2:0] code, input int limit);
    int n;
    n = 0;
    while (clock_source_sel !== code && n < limit)
    begin
        @(posedge aclk);
        n++;
    end
endtask

////////////////////////////////////////////////////////////////////////////////
// Main sequence
initial
begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, ext_clk_pin, ext_run} = '0;
    {reset_osc_select, ext_osc_mode, clock_switch_enable} = '0;
    s_axi_wstrb = 4'h1;
    hfint_ready = 1'b1;
    lfint_ready = 1'b1;
    {err_count, comparisons, cycles} = '0;
    // Boot on the 4 MHz internal source with switching allowed
    do_reset(osc_select_pkg::SRC_HFINT_4M, osc_select_pkg::EXT_HIGH_POWER_CLOCK, 1'b1);
    expect_reg("request boot", REQ, 32'h62, OK);
    expect_reg("status boot", CUR, 32'h62, OK);
    check("source out", 32'(clock_source_sel), 32'h6);
    check("ext mode", 32'(ext_mode_sel), 32'h0);
    foreach (rsv[i])
    begin
        axi_write(REQ, {25'h0, rsv[i], 4'h5});
        expect_reg("reserved write", REQ, 32'h62, OK);
    end
    // Byte strobe low: the request register must not take the data
    s_axi_wstrb <= 4'h0;
    axi_write(REQ, 32'h50);
    expect_reg("strobe off", REQ, 32'h62, OK);
    s_axi_wstrb <= 4'h1;
    // Low source not yet running: status must hold the old value
    lfint_ready <= 1'b0;
    axi_write(REQ, 32'hD1);
    expect_reg("request bit7", REQ, 32'h51, OK);
    repeat (20) @(posedge aclk);
    expect_reg("status held", CUR, 32'h62, OK);
    lfint_ready <= 1'b1;
    wait_src(osc_select_pkg::SRC_LFINT, 40);
    repeat (2) @(posedge aclk);
    expect_reg("status switched", CUR, 32'h51, OK);
    check("divider out", 32'(clock_divider_sel), 32'h1);
    axi_write(CUR, 32'h00);
    expect_reg("status readonly", CUR, 32'h51, OK);
    expect_reg("unmapped", 4'hC, 32'h0, osc_select_pkg::RESP_SLVERR);
    // External clock mode, then the pin stops and the monitor steps in
    ext_run <= 1'b1;
    axi_write(REQ, 32'h23);
    wait_src(osc_select_pkg::SRC_EXTERNAL, 40);
    check("ext source", 32'(clock_source_sel), 32'h2);
    check("amp off", 32'(crystal_amp_enable), 32'h0);
    ext_run <= 1'b0;
    repeat (4000) @(posedge aclk);
    check("no early fallback", 32'(clock_source_sel), 32'h2);
    wait_src(osc_select_pkg::SRC_HFINT_4M, 200);
    check("fallback source", 32'(clock_source_sel), 32'h6);
    check("fallback flag", 32'(failsafe_active), 32'h1);
    check("fallback divider", 32'(clock_divider_sel), 32'h3);
    expect_reg("monitor", osc_select_pkg::MON_STATUS_OFFSET, 32'h1, OK);
    // Crystal mode waits for the startup count of pin edges
    do_reset(osc_select_pkg::SRC_HFINT_32M, osc_select_pkg::EXT_MEDIUM_GAIN_CRYSTAL, 1'b1);
    expect_reg("request 32M", REQ, 32'h00, OK);
    check("crystal mode", 32'(ext_mode_sel), 32'h5);
    ext_run <= 1'b1;
    axi_write(REQ, 32'h20);
    repeat (1800) @(posedge aclk);
    check("crystal not yet", 32'(clock_source_sel), 32'h0);
    check("amp on", 32'(crystal_amp_enable), 32'h1);
    wait_src(osc_select_pkg::SRC_EXTERNAL, 400);
    check("crystal source", 32'(clock_source_sel), 32'h2);
    // Switching locked by the strap
    ext_run <= 1'b0;
    do_reset(osc_select_pkg::SRC_LFINT, osc_select_pkg::EXT_HIGH_POWER_CLOCK, 1'b0);
    expect_reg("request LF", REQ, 32'h50, OK);
    axi_write(REQ, 32'h06);
    expect_reg("request locked", REQ, 32'h50, OK);
    expect_reg("status LF", CUR, 32'h50, OK);
    stop_test();
end
endmodule // testbench
